// ==== tss_pkg.sv ====
package tss_pkg;

   // register map offsets
   localparam logic [7:0] ADDR_NOISE_THRESHOLD_SELECT  = 8'h38;
   localparam logic [7:0] ADDR_STANDBY_INPUT_ENABLE    = 8'h40;
   localparam logic [7:0] ADDR_STANDBY_SAMPLING_CONFIG = 8'h41;
   localparam logic [7:0] ADDR_STANDBY_GAIN_SELECT     = 8'h42;
   localparam logic [7:0] ADDR_STANDBY_THRESHOLD       = 8'h43;

   // values after reset
   localparam logic [1:0] RST_NOISE_LEVEL_FRACTION     = 2'h1;
   localparam logic [7:0] RST_STANDBY_INPUT_ENABLE     = 8'h00;
   localparam logic [7:0] RST_STANDBY_SAMPLING_CONFIG  = 8'h39;
   localparam logic [2:0] RST_STANDBY_GAIN             = 3'h2;
   localparam logic [6:0] RST_STANDBY_THRESHOLD        = 7'h40;

   // field positions inside the sampling configuration register
   localparam int CFG_ACCUMULATE_BIT = 7;
   localparam int CFG_COUNT_LSB      = 4;
   localparam int CFG_DURATION_LSB   = 2;
   localparam int CFG_PERIOD_LSB     = 0;

   // noise fraction is (code + NOISE_FRAC_BASE) eighths of the touch threshold
   localparam logic [2:0] NOISE_FRAC_BASE  = 3'h2;
   localparam int         NOISE_FRAC_SHIFT = 3;

   // gain: multiplier is 2^(GAIN_MAX_SHIFT - code), 128x down to 1x
   localparam logic [2:0] GAIN_MAX_SHIFT = 3'h7;

   // timing, figures in their own unit, converted at the 40 MHz clock
   localparam int CLOCK_KHZ            = 40000;
   localparam int STBY_SAMPLE_BASE_US  = 320;
   localparam int STBY_CYCLE_BASE_MS   = 35;
   localparam int STBY_SAMPLE_BASE_CYC = STBY_SAMPLE_BASE_US * CLOCK_KHZ / 1000;
   localparam int STBY_CYCLE_BASE_CYC  = STBY_CYCLE_BASE_MS * CLOCK_KHZ;

   typedef enum logic [1:0] {
      TSS_OFF,
      TSS_SAMPLE,
      TSS_REST
   } tss_state_t;

endpackage

// ==== tss_standby_sampler.sv ====
`timescale 1ns/100ps
module tss_standby_sampler
   import tss_pkg::*;
#(
   parameter int SAMPLE_BASE_CYC = STBY_SAMPLE_BASE_CYC,
   parameter int CYCLE_BASE_CYC  = STBY_CYCLE_BASE_CYC
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // register port from the serial interface engine
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // control bits held elsewhere in the device
   input  wire logic        noise_exclusion_off,
   input  wire logic        standby,
   // normal-mode sample check for the recalibration routine
   input  wire logic        norm_valid,
   input  wire logic [7:0]  norm_delta,
   input  wire logic [6:0]  norm_threshold,
   output logic             recal_use,
   output logic             noise_flag,
   // analog front end in standby
   output logic             afe_active,
   output logic      [2:0]  afe_channel,
   input  wire logic [15:0] afe_delta,
   // standby results
   output logic             result_valid,
   output logic      [2:0]  result_channel,
   output logic      [7:0]  result_delta,
   output logic      [7:0]  standby_touch
);

   // software-visible registers
   logic [1:0] noise_level_fraction;
   logic [7:0] standby_input_enable;
   logic [7:0] standby_sampling_config;
   logic [2:0] standby_gain;
   logic [6:0] standby_threshold;

   // per-cycle copies so a cycle runs on one consistent setting
   logic [7:0] en_shadow;
   logic       accumulate_not_average;
   logic [2:0] standby_sample_count;
   logic [1:0] standby_sample_duration;
   logic [1:0] standby_cycle_period;
   logic [2:0] gain_shadow;
   logic [6:0] thr_shadow;

   tss_state_t state;
   tss_state_t next_state;
   logic [2:0]  ch_idx;
   logic [16:0] samp_cnt;
   logic [7:0]  set_cnt;
   logic [23:0] cyc_cnt;
   logic signed [23:0] acc;

   // register decode
   wire wr_noise = reg_wr && (reg_addr == ADDR_NOISE_THRESHOLD_SELECT);
   wire wr_en    = reg_wr && (reg_addr == ADDR_STANDBY_INPUT_ENABLE);
   wire wr_cfg   = reg_wr && (reg_addr == ADDR_STANDBY_SAMPLING_CONFIG);
   wire wr_gain  = reg_wr && (reg_addr == ADDR_STANDBY_GAIN_SELECT);
   wire wr_thr   = reg_wr && (reg_addr == ADDR_STANDBY_THRESHOLD);
   wire [7:0] rd_mux =
      (reg_addr == ADDR_NOISE_THRESHOLD_SELECT)  ? {6'h00, noise_level_fraction} :
      (reg_addr == ADDR_STANDBY_INPUT_ENABLE)    ? standby_input_enable :
      (reg_addr == ADDR_STANDBY_SAMPLING_CONFIG) ? standby_sampling_config :
      (reg_addr == ADDR_STANDBY_GAIN_SELECT)     ? {5'h00, standby_gain} :
      (reg_addr == ADDR_STANDBY_THRESHOLD)       ? {1'b0, standby_threshold} : 8'h00;

   // register writes; reserved bits are dropped on write and read as zero
   always_ff @(posedge clock) begin
      if (reset) begin
         noise_level_fraction    <= RST_NOISE_LEVEL_FRACTION;
         standby_input_enable    <= RST_STANDBY_INPUT_ENABLE;
         standby_sampling_config <= RST_STANDBY_SAMPLING_CONFIG;
         standby_gain            <= RST_STANDBY_GAIN;
         standby_threshold       <= RST_STANDBY_THRESHOLD;
         reg_rdata               <= 8'h00;
      end else begin
         if (wr_noise) noise_level_fraction <= reg_wdata[1:0];
         if (wr_en)    standby_input_enable <= reg_wdata;
         if (wr_cfg)   standby_sampling_config <= reg_wdata;
         if (wr_gain)  standby_gain <= reg_wdata[2:0];
         if (wr_thr)   standby_threshold <= reg_wdata[6:0];
         if (reg_rd)   reg_rdata <= rd_mux;
      end
   end

   // noise band: above (code+2)/8 of the touch threshold, not above the threshold
   wire [10:0] delta_x8  = {norm_delta, 3'b000};
   wire [2:0]  frac_mul  = {1'b0, noise_level_fraction} + NOISE_FRAC_BASE;
   // product is formed at full width; a 7-bit product would wrap for large thresholds
   wire [10:0] noise_lim = {4'h0, norm_threshold} * {8'h00, frac_mul};
   wire in_noise_band    = (delta_x8 > noise_lim) && ({1'b0, norm_delta} <= {2'b00, norm_threshold});
   wire exclude_sample   = in_noise_band && !noise_exclusion_off;

   always_ff @(posedge clock) begin
      if (reset) begin
         recal_use  <= 1'b0;
         noise_flag <= 1'b0;
      end else begin
         recal_use  <= norm_valid && !exclude_sample;
         noise_flag <= norm_valid && in_noise_band;
      end
   end

   // sampling timing from the cycle's settings
   wire [16:0] samp_len   = 17'(SAMPLE_BASE_CYC) << standby_sample_duration;
   wire [23:0] cyc_len    = 24'(CYCLE_BASE_CYC) * ({1'b0, standby_cycle_period} + 3'h1);
   wire [7:0]  set_len    = 8'h01 << standby_sample_count;
   // standby falling mid-sample stops the front end and drops the partial sample
   wire        sampling   = (state == TSS_SAMPLE) && standby;
   wire        ch_on      = en_shadow[ch_idx];
   wire        samp_done  = sampling && ch_on && (samp_cnt == samp_len - 17'h1);
   wire        set_done   = samp_done && (set_cnt == set_len - 8'h01);
   wire        last_ch    = (ch_idx == 3'h7);
   wire        ch_advance = (state == TSS_SAMPLE) && (!ch_on || set_done);
   wire        cyc_over   = (cyc_cnt >= cyc_len - 24'h1);
   wire        cycle_start;

   // delta count: sum or average, then gain, then saturate to the 8-bit count
   // saturation keeps a large summed touch from wrapping into a negative count
   wire signed [23:0] sum_full  = acc + 24'(signed'(afe_delta));
   wire signed [23:0] avg_full  = sum_full >>> standby_sample_count;
   wire signed [23:0] chosen    = accumulate_not_average ? sum_full : avg_full;
   wire signed [31:0] scaled    = 32'(chosen) <<< (GAIN_MAX_SHIFT - gain_shadow);
   wire        [7:0]  sat_delta = (scaled > 32'sd127)  ? 8'h7F :
                                  (scaled < -32'sd128) ? 8'h80 : scaled[7:0];
   wire               is_touch  = $signed(sat_delta) > $signed({1'b0, thr_shadow});

   // sequencer next state
   always_comb begin
      next_state = state;
      unique case (state)
         TSS_OFF:    if (standby) next_state = TSS_SAMPLE;
         TSS_SAMPLE: if (ch_advance && last_ch) next_state = cyc_over ? TSS_SAMPLE : TSS_REST;
         TSS_REST:   if (cyc_over) next_state = TSS_SAMPLE;
      endcase
      if (!standby) next_state = TSS_OFF;
   end
   assign cycle_start = standby && ((state == TSS_OFF) || (state == TSS_REST && cyc_over) ||
                                    (state == TSS_SAMPLE && ch_advance && last_ch && cyc_over));

   // settings are sampled only when a cycle begins
   always_ff @(posedge clock) begin
      if (reset) begin
         en_shadow               <= RST_STANDBY_INPUT_ENABLE;
         accumulate_not_average  <= RST_STANDBY_SAMPLING_CONFIG[CFG_ACCUMULATE_BIT];
         standby_sample_count    <= RST_STANDBY_SAMPLING_CONFIG[CFG_COUNT_LSB +: 3];
         standby_sample_duration <= RST_STANDBY_SAMPLING_CONFIG[CFG_DURATION_LSB +: 2];
         standby_cycle_period    <= RST_STANDBY_SAMPLING_CONFIG[CFG_PERIOD_LSB +: 2];
         gain_shadow             <= RST_STANDBY_GAIN;
         thr_shadow              <= RST_STANDBY_THRESHOLD;
      end else if (cycle_start) begin
         en_shadow               <= standby_input_enable;
         accumulate_not_average  <= standby_sampling_config[CFG_ACCUMULATE_BIT];
         standby_sample_count    <= standby_sampling_config[CFG_COUNT_LSB +: 3];
         standby_sample_duration <= standby_sampling_config[CFG_DURATION_LSB +: 2];
         standby_cycle_period    <= standby_sampling_config[CFG_PERIOD_LSB +: 2];
         gain_shadow             <= standby_gain;
         thr_shadow              <= standby_threshold;
      end
   end

   // cycle counter saturates so an overlong sampling phase cannot wrap it
   always_ff @(posedge clock) begin
      if (reset || cycle_start || !standby) cyc_cnt <= 24'h000000;
      else if (cyc_cnt != 24'hFFFFFF)       cyc_cnt <= cyc_cnt + 24'h000001;
   end

   // state, channel pointer and per-channel sample counters
   always_ff @(posedge clock) begin
      if (reset) begin
         state    <= TSS_OFF;
         ch_idx   <= 3'h0;
         samp_cnt <= 17'h00000;
         set_cnt  <= 8'h00;
         acc      <= 24'sh000000;
      end else begin
         state <= next_state;
         if (cycle_start || ch_advance) begin
            ch_idx   <= cycle_start ? 3'h0 : ch_idx + 3'h1;
            samp_cnt <= 17'h00000;
            set_cnt  <= 8'h00;
            acc      <= 24'sh000000;
         end else if (state == TSS_SAMPLE) begin
            samp_cnt <= samp_done ? 17'h00000 : samp_cnt + 17'h00001;
            if (samp_done) begin
               set_cnt <= set_cnt + 8'h01;
               acc     <= sum_full;
            end
         end
      end
   end

   // a channel's result only changes after its whole sample set
   always_ff @(posedge clock) begin
      if (reset) begin
         result_valid   <= 1'b0;
         result_channel <= 3'h0;
         result_delta   <= 8'h00;
         standby_touch  <= 8'h00;
      end else begin
         result_valid <= set_done;
         if (set_done) begin
            result_channel        <= ch_idx;
            result_delta          <= sat_delta;
            standby_touch[ch_idx] <= is_touch;
         end
      end
   end

   // the front end only runs while standby still holds
   assign afe_active  = sampling && ch_on;
   assign afe_channel = ch_idx;

   // helper: samples counted on the current channel, for checking only
   logic [8:0] chk_samples;
   always_ff @(posedge clock) begin
      if (reset || cycle_start || ch_advance) chk_samples <= 9'h000;
      else if (samp_done)                     chk_samples <= chk_samples + 9'h001;
   end

   a_reset_values: assert property (@(posedge clock) reset ##1 1'h1 |->
      noise_level_fraction == 2'h1 && standby_input_enable == 8'h00 &&
      standby_sampling_config == 8'h39 && standby_gain == 3'h2 && standby_threshold == 7'h40)
      else $error("register reset value wrong");
   a_noise_excluded: assert property (@(posedge clock) disable iff (reset)
      norm_valid && in_noise_band && !noise_exclusion_off |=> !recal_use && noise_flag)
      else $error("noise sample reached recalibration");
   a_exclusion_off: assert property (@(posedge clock) disable iff (reset)
      norm_valid && noise_exclusion_off |=> recal_use)
      else $error("sample dropped while exclusion disabled");
   a_disabled_idle: assert property (@(posedge clock) disable iff (reset)
      afe_active |-> en_shadow[afe_channel] && standby)
      else $error("disabled input sampled");
   a_full_set: assert property (@(posedge clock) disable iff (reset)
      set_done |-> chk_samples == {1'b0, set_len} - 9'h001)
      else $error("result before full sample set");
   a_channel_held: assert property (@(posedge clock) disable iff (reset)
      afe_active && !set_done && !cycle_start |=> afe_channel == $past(afe_channel))
      else $error("channel changed inside a sample set");
   a_touch_compare: assert property (@(posedge clock) disable iff (reset)
      result_valid |-> standby_touch[result_channel] ==
         ($signed(result_delta) > $signed({1'b0, $past(thr_shadow)})))
      else $error("touch decision disagrees with threshold");
   a_cycle_length: assert property (@(posedge clock) disable iff (reset)
      cycle_start && state != TSS_OFF |-> cyc_cnt >= cyc_len - 24'h1)
      else $error("standby cycle ended early");
   a_config_stable: assert property (@(posedge clock) disable iff (reset)
      state != TSS_OFF && !$past(cycle_start) |-> $stable(en_shadow) && $stable(gain_shadow))
      else $error("settings changed mid-cycle");
   a_rest_quiet: assert property (@(posedge clock) disable iff (reset)
      state == TSS_REST |-> !afe_active)
      else $error("sampling during rest");

   // further checks on the noise path and the standby sequencer
   a_noise_upper: assert property (@(posedge clock) disable iff (reset)
      norm_valid && ({1'h0, norm_delta} > {2'h0, norm_threshold}) |=> recal_use && !noise_flag)
      else $error("touch-level sample treated as noise");
   a_noise_idle: assert property (@(posedge clock) disable iff (reset)
      !norm_valid |=> !recal_use && !noise_flag)
      else $error("noise result without a sample");
   a_abort_quiet: assert property (@(posedge clock) disable iff (reset)
      !standby |=> state == TSS_OFF && !afe_active)
      else $error("sampling outside standby");
   a_touch_kept: assert property (@(posedge clock) disable iff (reset)
      !set_done |=> $stable(standby_touch))
      else $error("touch bits changed without a full set");
   a_rest_length: assert property (@(posedge clock) disable iff (reset)
      cycle_start && state == TSS_REST |-> cyc_cnt == cyc_len - 24'h1)
      else $error("rest phase ended off the period");
   a_first_channel: assert property (@(posedge clock) disable iff (reset)
      cycle_start |=> afe_channel == 3'h0)
      else $error("cycle did not start at the first input");

   // main scenarios that the bench is expected to reach
   c_touch_seen:  cover property (@(posedge clock) result_valid && |standby_touch);
   c_rest_phase:  cover property (@(posedge clock) state == TSS_SAMPLE ##1 state == TSS_REST);
   c_noise_spike: cover property (@(posedge clock) norm_valid && exclude_sample);
   c_stretch:     cover property (@(posedge clock) cycle_start && state == TSS_SAMPLE);
   c_sum_result:  cover property (@(posedge clock) result_valid && accumulate_not_average);

endmodule

// ==== tss_afe_model.sv ====
`timescale 1ns/100ps
// front end stand-in: returns the level the bench sets while a channel is sampled
module tss_afe_model (
   // clock
   input  wire logic        clock,
   // sampling control from the sampler, sample level from the bench
   input  wire logic        afe_active,
   input  wire logic [2:0]  afe_channel,
   input  wire logic [15:0] level,
   // measured delta
   output logic      [15:0] afe_delta
);
   logic [15:0] junk = 16'hA5A5;

   // idle front end shows a changing pattern, so a stale read cannot match by luck
   always_ff @(posedge clock) begin
      junk <= ~junk ^ {13'h0000, afe_channel};
   end

   assign afe_delta = afe_active ? level : junk;
endmodule

// ==== touch_standby_sampling_config_tb.sv ====
`timescale 1ns/100ps
module touch_standby_sampling_config_tb;
   import tss_pkg::*;
   typedef struct {logic [7:0] addr; logic [7:0] wd; logic [7:0] rst; logic [7:0] back;} tss_reg_t;
   typedef struct {logic [1:0] code; logic off; logic [7:0] dl; logic rec; logic nz;} tss_nz_t;
   typedef struct {logic [7:0] cfg; logic [7:0] gain; logic [15:0] lvl; logic [7:0] res;
                   logic hit; int act;} tss_sby_t;
   // clock, reset and drivers
   logic        clock = 1'h0;
   logic        reset = 1'h1;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, norm_delta = 8'h00, rdv;
   logic        reg_wr = 1'h0, reg_rd = 1'h0, noise_exclusion_off = 1'h0;
   logic        standby = 1'h0, norm_valid = 1'h0;
   logic [6:0]  norm_threshold = 7'h40;
   logic [15:0] level = 16'h0000, afe_delta;
   // observed outputs
   logic [7:0]  reg_rdata, result_delta, standby_touch;
   logic        recal_use, noise_flag, afe_active, result_valid;
   logic [2:0]  afe_channel, result_channel;
   int          error_cnt = 0, total_checks = 0, cyc = 0, act, gap;
   tss_reg_t regs [6] = '{'{8'h38, 8'hFF, 8'h01, 8'h03}, '{8'h40, 8'h5A, 8'h00, 8'h5A},
      '{8'h41, 8'hA5, 8'h39, 8'hA5}, '{8'h42, 8'hFF, 8'h02, 8'h07},
      '{8'h43, 8'hFF, 8'h40, 8'h7F}, '{8'h44, 8'hAA, 8'h00, 8'h00}};
   tss_nz_t nzs [9] = '{'{2'h0, 1'h0, 8'h11, 1'h0, 1'h1}, '{2'h0, 1'h0, 8'h10, 1'h1, 1'h0},
      '{2'h1, 1'h0, 8'h19, 1'h0, 1'h1}, '{2'h1, 1'h0, 8'h18, 1'h1, 1'h0},
      '{2'h2, 1'h0, 8'h21, 1'h0, 1'h1}, '{2'h3, 1'h0, 8'h28, 1'h1, 1'h0},
      '{2'h3, 1'h0, 8'h29, 1'h0, 1'h1}, '{2'h3, 1'h1, 8'h29, 1'h1, 1'h1},
      '{2'h1, 1'h0, 8'h41, 1'h1, 1'h0}};
   // short sample lengths keep the run brief: S = 4 << duration, cycle = 200 * (period + 1)
   tss_sby_t sby [6] = '{'{8'h10, 8'h07, 16'h0014, 8'h14, 1'h1, 8},
      '{8'h90, 8'h07, 16'h0014, 8'h28, 1'h1, 8}, '{8'h2C, 8'h05, 16'h0014, 8'h50, 1'h1, 128},
      '{8'h04, 8'h00, 16'h0014, 8'h7F, 1'h1, 8}, '{8'h08, 8'h07, 16'hFFEC, 8'hEC, 1'h0, 16},
      '{8'h70, 8'h07, 16'h0014, 8'h14, 1'h1, 512}};

   tss_standby_sampler #(.SAMPLE_BASE_CYC(4), .CYCLE_BASE_CYC(200)) tss_standby_sampler_inst (
      .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .noise_exclusion_off(noise_exclusion_off), .standby(standby), .norm_valid(norm_valid),
      .norm_delta(norm_delta), .norm_threshold(norm_threshold), .recal_use(recal_use),
      .noise_flag(noise_flag), .afe_active(afe_active), .afe_channel(afe_channel),
      .afe_delta(afe_delta), .result_valid(result_valid), .result_channel(result_channel),
      .result_delta(result_delta), .standby_touch(standby_touch));
   tss_afe_model tss_afe_model_inst (.clock(clock), .afe_active(afe_active),
      .afe_channel(afe_channel), .level(level), .afe_delta(afe_delta));

   always #12.5 clock = ~clock;

   // a hang ends the run as a failure
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock); #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(posedge clock); #1;
      reg_wr = 1'h0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clock); #1;
      reg_addr = a;
      reg_rd = 1'h1;
      @(posedge clock); #1;
      reg_rd = 1'h0;
      rdv = reg_rdata;
   endtask

   // counts sampling clocks up to the next result; bounded so a lost result cannot hang
   task automatic wait_res();
      act = 0;
      for (int i = 0; i < 1500; i++) begin
         @(posedge clock); #1;
         gap = i + 1;
         if (result_valid === 1'h1) return;
         if (afe_active === 1'h1) act++;
      end
      error_cnt++;
      tally_and_finish();
   endtask

   initial begin
      repeat (12) @(posedge clock);
      #1 reset = 1'h0;
      foreach (regs[i]) begin
         rd(regs[i].addr);
         chk("reset_value", 16'(regs[i].rst), 16'(rdv));
         wr(regs[i].addr, regs[i].wd);
         rd(regs[i].addr);
         chk("readback", 16'(regs[i].back), 16'(rdv));
      end
      foreach (nzs[i]) begin
         wr(ADDR_NOISE_THRESHOLD_SELECT, {6'h00, nzs[i].code});
         noise_exclusion_off = nzs[i].off;
         norm_delta = nzs[i].dl;
         norm_valid = 1'h1;
         @(posedge clock); #1;
         norm_valid = 1'h0;
         chk("recal_use", 16'(nzs[i].rec), 16'(recal_use));
         chk("noise_flag", 16'(nzs[i].nz), 16'(noise_flag));
      end
      wr(ADDR_STANDBY_THRESHOLD, 8'h10);
      wr(ADDR_STANDBY_INPUT_ENABLE, 8'h05);
      // inputs 0 and 2 enabled; a gain write mid-cycle must not touch input 2's result
      foreach (sby[i]) begin
         wr(ADDR_STANDBY_SAMPLING_CONFIG, sby[i].cfg);
         wr(ADDR_STANDBY_GAIN_SELECT, sby[i].gain);
         level = sby[i].lvl;
         standby = 1'h1;
         wait_res();
         chk("active_clocks", 16'(sby[i].act), 16'(act));
         chk("channel_first", 16'h0000, 16'(result_channel));
         chk("afe_channel", 16'h0001, 16'(afe_channel));
         chk("delta_first", 16'(sby[i].res), 16'(result_delta));
         wr(ADDR_STANDBY_GAIN_SELECT, sby[i].gain ^ 8'h01);
         wait_res();
         chk("channel_second", 16'h0002, 16'(result_channel));
         chk("delta_second", 16'(sby[i].res), 16'(result_delta));
         chk("touch", {13'h0000, sby[i].hit, 1'h0, sby[i].hit}, 16'(standby_touch));
         standby = 1'h0;
      end
      // period code 1 gives two base periods; 128 samples outlast the base period
      wr(ADDR_STANDBY_INPUT_ENABLE, 8'h01);
      wr(ADDR_STANDBY_SAMPLING_CONFIG, 8'h01);
      standby = 1'h1;
      wait_res();
      wait_res();
      chk("cycle_period", 16'h0190, 16'(gap));
      standby = 1'h0;
      wr(ADDR_STANDBY_SAMPLING_CONFIG, 8'h70);
      standby = 1'h1;
      wait_res();
      wait_res();
      chk("cycle_stretch", 16'h0001, 16'(gap > 512));
      // reset in mid-run clears results and restores the enable register
      reset = 1'h1;
      repeat (2) @(posedge clock);
      #1 reset = 1'h0;
      standby = 1'h0;
      chk("touch_after_reset", 16'h0000, 16'(standby_touch));
      chk("delta_after_reset", 16'h0000, 16'(result_delta));
      rd(ADDR_STANDBY_INPUT_ENABLE);
      chk("enable_after_reset", 16'h0000, 16'(rdv));
      rd(ADDR_STANDBY_GAIN_SELECT);
      chk("gain_after_reset", 16'h0002, 16'(rdv));
      tally_and_finish();
   end
endmodule
